/* File: logic/iprs_pkg.sv */
// package for the interrupt priority resolver
package iprs_pkg;
    // ---------------------------------------------------------------
    // polling levels and widths
    // ---------------------------------------------------------------
    localparam int unsigned NUM_NODES   = 14;
    localparam int unsigned NODE_W      = 4;
    localparam int unsigned LVL_W       = 2;
    localparam int unsigned NEST_W      = 4;
    localparam logic [NODE_W-1:0] NODE_NONE = 4'h0;
    localparam logic [NODE_W-1:0] NODE_NMI  = 4'hF;
    localparam logic [LVL_W-1:0]  LVL_LOW   = 2'h0;
    localparam logic [NODE_W-1:0] NODE_EXT0 = 4'h1;
    localparam logic [NODE_W-1:0] NODE_TMR0 = 4'h2;
    localparam logic [NODE_W-1:0] NODE_EXT1 = 4'h3;
    localparam logic [NODE_W-1:0] NODE_TMR1 = 4'h4;
    localparam logic [NODE_W-1:0] NODE_UART = 4'h5;
    localparam logic [NODE_W-1:0] NODE_L6   = 4'h6;
    localparam logic [NODE_W-1:0] NODE_L7   = 4'h7;
    localparam logic [NODE_W-1:0] NODE_SSC  = 4'h8;
    localparam logic [NODE_W-1:0] NODE_L9   = 4'h9;
    localparam logic [NODE_W-1:0] NODE_L10  = 4'hA;
    localparam logic [NODE_W-1:0] NODE_CCU0 = 4'hB;

    typedef enum logic [1:0] {
        IPRS_IDLE = 2'b00,
        IPRS_OFFER = 2'b01
    } iprs_state_e;
endpackage : iprs_pkg

/* File: logic/iprs_stack.sv */
// small register stack holding the levels of nested services
`timescale 1ns/10ps
`default_nettype none
module iprs_stack #(
    parameter int unsigned WIDTH = 3,
    parameter int unsigned DEPTH = 5
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // push and pop
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    // top of stack, registered
    output logic      [WIDTH-1:0] top_q,
    output logic                  empty,
    output logic                  full
);
    localparam int unsigned PW = $clog2(DEPTH + 1);
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
        $error("iprs_stack: bad size");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    cnt_q;
    assign empty = (cnt_q == '0);
    assign full  = (cnt_q == PW'(DEPTH));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            top_q <= '0;
        end else if (clk_en) begin
            if (push && !full) begin
                mem_q[cnt_q] <= push_data;
                cnt_q        <= cnt_q + PW'(1);
                top_q        <= push_data;
            end else if (pop && !empty) begin
                cnt_q <= cnt_q - PW'(1);
                top_q <= (cnt_q > PW'(1)) ? mem_q[cnt_q - PW'(2)] : '0;
            end
        end
    end
endmodule // iprs_stack
`default_nettype wire

/* File: logic/iprs_resolver.sv */
// interrupt priority resolver: ranks requests and vectors the core
`timescale 1ns/10ps
`default_nettype none
module iprs_resolver
    import iprs_pkg::*;
#(
    parameter int unsigned NEST_DEPTH = 5
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // global enable and nmi
    input  wire logic                 global_en,
    input  wire logic                 nmi_req,
    // single sources, levels 1 to 5 and 8
    input  wire logic                 ext0_req,
    input  wire logic                 tmr0_req,
    input  wire logic                 ext1_req,
    input  wire logic                 tmr1_req,
    input  wire logic                 uart_req,
    input  wire logic                 sync_serial_channel_req,
    // shared level 6
    input  wire logic                 gp_timer_req,
    input  wire logic                 uart_div_ovf_req,
    input  wire logic                 can_l6_req,
    input  wire logic                 lin_req,
    // shared level 7
    input  wire logic                 adc_req,
    input  wire logic                 can_l7_req,
    // shared level 9
    input  wire logic                 ext2_req,
    input  wire logic                 aux_timer_req,
    input  wire logic                 second_uart_req,
    input  wire logic                 second_uart_div_ovf_req,
    input  wire logic                 muldiv_unit_req,
    input  wire logic                 rotation_coprocessor_req,
    // shared level 10
    input  wire logic [3:0]           ext3_6_req,
    input  wire logic                 can_l10_req,
    // levels 11 to 14
    input  wire logic [3:0]           capture_compare_unit_req,
    input  wire logic [3:0]           can_l11_14_req,
    // per node enables and priority bits, bit n-1 is node n
    input  wire logic [NUM_NODES-1:0] node_en,
    input  wire logic [NUM_NODES-1:0] prio_lo,
    input  wire logic [NUM_NODES-1:0] prio_hi,
    // core side
    input  wire logic                 ack,
    input  wire logic                 reti,
    output logic                      irq,
    output logic [NODE_W-1:0]         irq_node,
    output logic                      in_service,
    output logic [NODE_W-1:0]         served_node
);
    // nesting deeper than the 14 nodes plus nmi buys nothing
    if (NEST_DEPTH < 1 || NEST_DEPTH > 15) begin : g_bad_depth
        $error("bad NEST_DEPTH");
    end

    // ---------------------------------------------------------------
    // level encoding: nmi sits above all maskable levels
    // ---------------------------------------------------------------
    function automatic logic [2:0] eff_lvl(input logic hi, input logic lo);
        eff_lvl = {1'b0, hi, lo} + 3'h1;
    endfunction
    localparam logic [2:0] LVL_NMI = 3'h5;

    // ---------------------------------------------------------------
    // group sources into polling nodes
    // ---------------------------------------------------------------
    logic [NUM_NODES-1:0] node_req;
    always_comb begin
        node_req[0]  = ext0_req;
        node_req[1]  = tmr0_req;
        node_req[2]  = ext1_req;
        node_req[3]  = tmr1_req;
        node_req[4]  = uart_req;
        node_req[5]  = gp_timer_req | uart_div_ovf_req
                     | can_l6_req | lin_req;
        node_req[6]  = adc_req | can_l7_req;
        node_req[7]  = sync_serial_channel_req;
        node_req[8]  = ext2_req | aux_timer_req | second_uart_req
                     | second_uart_div_ovf_req | muldiv_unit_req
                     | rotation_coprocessor_req;
        node_req[9]  = (|ext3_6_req) | can_l10_req;
        node_req[13:10] = capture_compare_unit_req
                        | can_l11_14_req;
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        iprs_state_e      st;
        logic [NODE_W-1:0] node;
        logic [NODE_W-1:0] served;
        logic              nmi_seen;
    } iprs_s;
    iprs_s s_q, s_d;

    logic [2:0] cur_lvl;
    logic [2:0] win_lvl_hold;
    logic       stk_empty, stk_full, push, pop;

    // ---------------------------------------------------------------
    // ranking: highest level, ties by lowest node number
    // ---------------------------------------------------------------
    logic [2:0]        win_lvl;
    logic [NODE_W-1:0] win_node;
    logic              nmi_edge;
    always_comb begin
        win_lvl  = 3'h0;
        win_node = NODE_NONE;
        nmi_edge = nmi_req && !s_q.nmi_seen;
        if (nmi_edge) begin
            win_lvl  = LVL_NMI;
            win_node = NODE_NMI;
        end else if (global_en) begin
            for (int i = NUM_NODES - 1; i >= 0; i--) begin
                if (node_req[i] && node_en[i]
                    && eff_lvl(prio_hi[i], prio_lo[i]) >= win_lvl) begin
                    win_lvl  = eff_lvl(prio_hi[i], prio_lo[i]);
                    win_node = NODE_W'(i + 1);
                end
            end
        end
    end

    // strictly above the running level, and room to nest
    logic grant_ok;
    assign grant_ok = (win_lvl > cur_lvl) && !stk_full;

    // ---------------------------------------------------------------
    // offer held until the core acknowledges
    // ---------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        push     = 1'b0;
        pop      = 1'b0;
        // an nmi edge stays pending while nmi_req is held until offered, also when it rises during an offer
        s_d.nmi_seen = s_q.nmi_seen & nmi_req;
        case (s_q.st)
            IPRS_IDLE: begin
                if (reti && !stk_empty) begin
                    pop = 1'b1;
                end else if (grant_ok) begin
                    s_d.st   = IPRS_OFFER;
                    s_d.node = win_node;
                    if (win_node == NODE_NMI) begin
                        s_d.nmi_seen = 1'b1;
                    end
                end
            end
            IPRS_OFFER: begin
                if (ack) begin
                    push       = 1'b1;
                    s_d.served = s_q.node;
                    s_d.st     = IPRS_IDLE;
                end
            end
            default: s_d.st = IPRS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{st: IPRS_IDLE, node: NODE_NONE,
                     served: NODE_NONE, nmi_seen: 1'b0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // levels of nested services; a lower holder resumes at reti
    iprs_stack #(.WIDTH(3), .DEPTH(NEST_DEPTH)) u_stack (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .push      (push),
        .push_data (s_q.node == NODE_NMI ? LVL_NMI : win_lvl_hold),
        .pop       (pop),
        .top_q     (cur_lvl),
        .empty     (stk_empty),
        .full      (stk_full)
    );

    // level of the offered node, recomputed from its priority bits
    always_comb begin
        win_lvl_hold = 3'h1;
        for (int i = 0; i < NUM_NODES; i++) begin
            if (s_q.node == NODE_W'(i + 1)) begin
                win_lvl_hold = eff_lvl(prio_hi[i], prio_lo[i]);
            end
        end
    end

    assign irq         = (s_q.st == IPRS_OFFER);
    assign irq_node    = s_q.node;
    assign in_service  = !stk_empty;
    assign served_node = s_q.served;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_NO_EQUAL_PREEMPT: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_q.st == IPRS_IDLE && s_d.st == IPRS_OFFER)
            |-> win_lvl > cur_lvl)
        else $error("grant without strictly higher level");
    AST_HIGH_LEVEL_WINS: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_q.st == IPRS_IDLE && s_d.st == IPRS_OFFER
         && s_d.node != NODE_NMI)
            |=> irq && win_lvl_hold == $past(win_lvl))
        else $error("offered level is not the highest");
    AST_TIE_LOW_NODE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !nmi_edge && global_en && node_req[0] && node_en[0]
         && prio_hi[0] && prio_lo[0]) |-> win_node == NODE_EXT0)
        else $error("tie not broken by polling order");
    AST_NMI_FIRST: assert property (
        @(posedge clk) disable iff (!rst_n)
        nmi_edge |-> win_node == NODE_NMI)
        else $error("nmi not ranked first");
    AST_OFFER_HOLDS: assert property (
        @(posedge clk) disable iff (!rst_n)
        (irq && !ack) ##1 clk_en |-> irq && $stable(irq_node))
        else $error("offer dropped before ack");
    AST_OFFER_ABOVE_SERVICE: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_q.st == IPRS_IDLE && s_d.st == IPRS_OFFER)
            |=> ((irq_node == NODE_NMI) ? LVL_NMI : win_lvl_hold)
                > cur_lvl)
        else $error("offered level not above the running level");
    AST_NMI_TAKEN: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_q.st == IPRS_IDLE && nmi_edge && !reti
         && !stk_full && cur_lvl != LVL_NMI)
            |=> irq && irq_node == NODE_NMI)
        else $error("pending nmi not offered");
endmodule // iprs_resolver
`default_nettype wire

/* File: tb/iprs_core_model.sv */
// core side model: takes offered vectors and ends services
`timescale 1ns/10ps
`default_nettype none
module iprs_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // offer from the resolver, wait before taking it
    input  wire logic       irq,
    input  wire logic [1:0] dly,
    // bench asks for a service end
    input  wire logic       end_req,
    // core answers
    output logic            ack,
    output logic            reti
);
    logic [1:0] cnt_q;
    // ack only while an offer stands, one cycle, after dly+1 cycles of offer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack   <= 1'b0;
            reti  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            reti <= end_req;
            if (irq && !ack) begin
                if (cnt_q == dly) begin
                    ack   <= 1'b1;
                    cnt_q <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end else begin
                ack <= 1'b0;
            end
        end
    end
endmodule // iprs_core_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking testbench for the interrupt priority resolver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import iprs_pkg::*;
    logic        clk = 0, rst_n = 0, nmi = 0, ge = 0, end_req = 0;
    logic        ce = 1;
    logic        ack, reti, irq, ins;
    logic [30:0] src = '0;
    logic [13:0] en = '0, lo = '0, hi = '0;
    logic [3:0]  node, srv, xp;
    logic [1:0]  dly = 2'h0;
    logic [31:0] rnd = 32'hFF78;
    int          err_count = 0, tests_run = 0;
    initial forever #5 clk = ~clk;
    // ---------------------------------------------------------------
    // design and core model
    // ---------------------------------------------------------------
    iprs_resolver u_dut (.clk(clk), .rst_n(rst_n), .clk_en(ce),
        .global_en(ge), .nmi_req(nmi), .ext0_req(src[0]), .tmr0_req(src[1]),
        .ext1_req(src[2]), .tmr1_req(src[3]), .uart_req(src[4]),
        .sync_serial_channel_req(src[5]), .gp_timer_req(src[6]),
        .uart_div_ovf_req(src[7]), .can_l6_req(src[8]), .lin_req(src[9]),
        .adc_req(src[10]), .can_l7_req(src[11]), .ext2_req(src[12]),
        .aux_timer_req(src[13]), .second_uart_req(src[14]),
        .second_uart_div_ovf_req(src[15]), .muldiv_unit_req(src[16]),
        .rotation_coprocessor_req(src[17]), .ext3_6_req(src[21:18]),
        .can_l10_req(src[22]), .capture_compare_unit_req(src[26:23]),
        .can_l11_14_req(src[30:27]), .node_en(en), .prio_lo(lo),
        .prio_hi(hi), .ack(ack), .reti(reti), .irq(irq), .irq_node(node),
        .in_service(ins), .served_node(srv));
    iprs_core_model u_core (.clk(clk), .rst_n(rst_n), .irq(irq),
        .dly(dly), .end_req(end_req), .ack(ack), .reti(reti));
    // ---------------------------------------------------------------
    // expectation helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] x);
        repeat (32) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction
    function automatic logic [3:0] node_of(int i);
        if (i < 5) return 4'(i + 1);
        if (i == 5) return 4'h8;
        if (i < 10) return 4'h6;
        if (i < 12) return 4'h7;
        if (i < 18) return 4'h9;
        if (i < 23) return 4'hA;
        return 4'(11 + (i - 23) % 4);
    endfunction
    // highest level first, lowest node number among equals
    function automatic logic [3:0] winner(int cur);
        int         l;
        logic [3:0] w;
        logic       r;
        w = 4'h0;
        for (int n = 1; n <= 14; n++) begin
            r = 1'b0;
            for (int i = 0; i < 31; i++) r |= src[i] && node_of(i) == n;
            l = {hi[n-1], lo[n-1]};
            if (ge && en[n-1] && r && l > cur) begin
                cur = l;
                w = 4'(n);
            end
        end
        return w;
    endfunction
    // ---------------------------------------------------------------
    // drivers
    // ---------------------------------------------------------------
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_irq(logic want);
        int k;
        k = 0;
        while (irq !== want && k < 50) begin
            step();
            k++;
        end
        if (irq !== want) begin
            err_count++;
            conclude();
        end
    endtask
    // the source is dropped during the offer, the vector must stand
    task automatic take(logic [3:0] exp);
        wait_irq(1'b1);
        `CHK(node, exp)
        for (int i = 0; i < 31; i++) if (node_of(i) == exp) src[i] = 1'b0;
        if (exp == NODE_NMI) nmi = 1'b0;
        wait_irq(1'b0);
        `CHK({ins, srv}, {1'b1, exp})
    endtask
    task automatic fin();
        end_req = 1'b1;
        step();
        end_req = 1'b0;
        step(2);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        #1;
        `CHK({irq, node, ins, srv}, 10'h000)
        rst_n = 1'b1;
        step();
        // every source at one level: polled strictly by node number
        ge = 1'b1;
        en = '1;
        lo = '1;
        src = '1;
        dly = 2'h3;
        for (int n = 1; n <= 14; n++) begin
            take(4'(n));
            fin();
        end
        // nesting: equal and lower wait, higher and nmi preempt
        lo = 14'h0005;
        hi = 14'h2000;
        src[2] = 1'b1;
        take(4'h3);
        src[1] = 1'b1;
        src[0] = 1'b1;
        step(5);
        `CHK(irq, 1'b0)
        src[30] = 1'b1;
        take(4'hE);
        nmi = 1'b1;
        take(NODE_NMI);
        fin();
        fin();
        step(3);
        `CHK(irq, 1'b0)
        fin();
        take(4'h1);
        fin();
        take(4'h2);
        fin();
        // frozen enable, nmi raised inside an offer, mid-run reset
        ce = 1'b0;
        src[0] = 1'b1;
        step(4);
        `CHK(irq, 1'b0)
        ce = 1'b1;
        wait_irq(1'b1);
        ce = 1'b0;
        nmi = 1'b1;
        step(6);
        `CHK({irq, node, ins}, 6'h22)
        ce = 1'b1;
        take(4'h1);
        take(NODE_NMI);
        rst_n = 1'b0;
        step();
        `CHK({irq, node, ins, srv}, 10'h000)
        rst_n = 1'b1;
        step();
        // random mixes of sources, enables and levels
        repeat (150) begin
            rnd = lfsr(rnd);
            src = rnd[30:0];
            rnd = lfsr(rnd);
            lo = rnd[13:0];
            hi = rnd[27:14];
            dly = rnd[29:28];
            rnd = lfsr(rnd);
            en = rnd[13:0] | rnd[27:14];
            ge = rnd[30] | rnd[31];
            xp = winner(-1);
            if (xp == 4'h0) begin
                step(3);
                `CHK(irq, 1'b0)
            end else begin
                take(xp);
                src = '0;
                fin();
            end
            src = '0;
            step();
        end
        conclude();
    end
endmodule // tb
`default_nettype wire
